// file: src/gpr_port_top.sv
`timescale 1ns/100ps
module gpr_port_top (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Per-pin configuration, plus the single global hold enable
  input wire logic [gpr_pkg::NUM_PINS*gpr_pkg::MODE_W-1:0] driveMode,
  input wire logic [gpr_pkg::NUM_PINS-1:0] inDisable,
  input wire logic [gpr_pkg::NUM_PINS-1:0] outDisable,
  input wire logic [gpr_pkg::NUM_PINS-1:0] thresholdLvttl,
  input wire logic [gpr_pkg::NUM_PINS-1:0] slewSlow,
  input wire logic [gpr_pkg::NUM_PINS*gpr_pkg::SRC_W-1:0] sourceSel,
  input wire logic holdEn,
  // Data output register write
  input wire logic doutWrite,
  input wire logic [2:0] doutPort,
  input wire logic [gpr_pkg::PORT_PINS-1:0] doutData,
  // Matrix sources
  input wire logic [gpr_pkg::NUM_PINS-1:0] fixedOut,
  input wire logic [gpr_pkg::FABRIC_PINS-1:0] programmableLogicBlockOut,
  // Interrupt control
  input wire logic [gpr_pkg::NUM_PINS-1:0] intEnable,
  input wire logic [gpr_pkg::NUM_PINS*gpr_pkg::EDGE_W-1:0] intEdgeSel,
  input wire logic [gpr_pkg::NUM_PINS-1:0] intClear,
  // Pads
  input wire logic [gpr_pkg::NUM_PINS-1:0] pinIn,
  output logic [gpr_pkg::NUM_PINS-1:0] pinOut,
  output logic [gpr_pkg::NUM_PINS-1:0] pinOe,
  output logic [gpr_pkg::NUM_PINS-1:0] pinPullUp,
  output logic [gpr_pkg::NUM_PINS-1:0] pinPullDown,
  output logic [gpr_pkg::NUM_PINS-1:0] pinWeak,
  output logic [gpr_pkg::NUM_PINS-1:0] pinInEn,
  output logic [gpr_pkg::NUM_PINS-1:0] pinSlewSlow,
  output logic [gpr_pkg::NUM_PINS-1:0] pinLvttl,
  // Status and routing
  output logic [gpr_pkg::NUM_PINS-1:0] dataOut,
  output logic [gpr_pkg::NUM_PINS-1:0] pinState,
  output logic [gpr_pkg::FABRIC_PINS-1:0] programmableLogicBlockIn,
  output logic [gpr_pkg::NUM_PINS-1:0] intStatus,
  output logic [gpr_pkg::NUM_PORTS-1:0] portServiceVector
);
  import gpr_pkg::*;

  // Pad control group
  logic [NUM_PINS-1:0] padOut_q, padOut_d;
  logic [NUM_PINS-1:0] padOe_q, padOe_d;
  logic [NUM_PINS-1:0] pullUp_q, pullUp_d;
  logic [NUM_PINS-1:0] pullDown_q, pullDown_d;
  logic [NUM_PINS-1:0] weak_q, weak_d;
  logic [NUM_PINS-1:0] inEn_q, inEn_d;
  logic [NUM_PINS-1:0] slew_q, slew_d;
  logic [NUM_PINS-1:0] lvttl_q, lvttl_d;
  // Cell outputs
  logic [NUM_PINS-1:0] cellOut, cellOe, cellUp, cellDown, cellWeak, cellInEn;
  logic [NUM_PINS-1:0] matrixOut;
  // Data, sampling and interrupt groups
  logic [NUM_PINS-1:0] dataOut_q, dataOut_d;
  logic [NUM_PINS-1:0] pinState_q, pinState_d;
  logic [NUM_PINS-1:0] prevState_q, prevState_d;
  logic [NUM_PINS-1:0] status_q, status_d;
  logic [NUM_PINS-1:0] pinEvent;
  logic primed_q, primed_d;

  function automatic logic [SRC_W-1:0] srcOf(input int pin);
    srcOf = sourceSel[pin*SRC_W +: SRC_W];
  endfunction

  // Matrix and pin cells
  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    always_comb begin
      matrixOut[i] = dataOut_q[i];
      if (srcOf(i) == SRC_FIXED) begin
        matrixOut[i] = fixedOut[i];
      end else if (srcOf(i) == SRC_FABRIC && i < FABRIC_PINS) begin
        matrixOut[i] = programmableLogicBlockOut[i % FABRIC_PINS];
      end
    end

    gpr_pin_cell u_cell (
      .driveMode(gpr_drive_t'(driveMode[i*MODE_W +: MODE_W])),
      .outDisable(outDisable[i]),
      .inDisable(inDisable[i]),
      .outValue(matrixOut[i]),
      .padOut(cellOut[i]),
      .padOe(cellOe[i]),
      .padPullUp(cellUp[i]),
      .padPullDown(cellDown[i]),
      .padWeak(cellWeak[i]),
      .padInEn(cellInEn[i])
    );
  end

  // Pad state latches while hold is on
  always_comb begin
    padOut_d = padOut_q;
    padOe_d = padOe_q;
    pullUp_d = pullUp_q;
    pullDown_d = pullDown_q;
    weak_d = weak_q;
    inEn_d = inEn_q;
    slew_d = slew_q;
    lvttl_d = lvttl_q;
    if (!holdEn) begin
      padOut_d = cellOut;
      padOe_d = cellOe;
      pullUp_d = cellUp;
      pullDown_d = cellDown;
      weak_d = cellWeak;
      inEn_d = cellInEn;
      slew_d = slewSlow;
      lvttl_d = thresholdLvttl;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      padOut_q <= PINS_RESET;
      padOe_q <= PINS_RESET;
      pullUp_q <= PINS_RESET;
      pullDown_q <= PINS_RESET;
      weak_q <= PINS_RESET;
      inEn_q <= PINS_RESET;
      slew_q <= PINS_RESET;
      lvttl_q <= PINS_RESET;
    end else begin
      padOut_q <= padOut_d;
      padOe_q <= padOe_d;
      pullUp_q <= pullUp_d;
      pullDown_q <= pullDown_d;
      weak_q <= weak_d;
      inEn_q <= inEn_d;
      slew_q <= slew_d;
      lvttl_q <= lvttl_d;
    end
  end

  // Data output register, one port byte per write
  always_comb begin
    dataOut_d = dataOut_q;
    if (doutWrite) begin
      dataOut_d[doutPort*PORT_PINS +: PORT_PINS] = doutData;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dataOut_q <= PINS_RESET;
    end else begin
      dataOut_q <= dataOut_d;
    end
  end

  // Pin state sampling, frozen during hold
  always_comb begin
    pinState_d = pinState_q;
    if (!holdEn) begin
      pinState_d = pinIn & cellInEn;
    end
    // First sample after reset seeds both, so no false edge
    prevState_d = primed_q ? pinState_q : pinState_d;
    primed_d = 1'b1;
    for (int i = 0; i < NUM_PINS; i++) begin
      pinEvent[i] = intEnable[i] &&
        ((intEdgeSel[i*EDGE_W+EDGE_RISE_BIT] && pinState_q[i] && !prevState_q[i]) ||
         (intEdgeSel[i*EDGE_W+EDGE_FALL_BIT] && !pinState_q[i] && prevState_q[i]));
    end
    status_d = (status_q & ~intClear) | pinEvent;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pinState_q <= PINS_RESET;
      prevState_q <= PINS_RESET;
      status_q <= PINS_RESET;
      primed_q <= 1'b0;
    end else begin
      pinState_q <= pinState_d;
      prevState_q <= prevState_d;
      status_q <= status_d;
      primed_q <= primed_d;
    end
  end

  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      portServiceVector[p] =
        |(status_q[p*PORT_PINS +: PORT_PINS] & intEnable[p*PORT_PINS +: PORT_PINS]);
    end
  end

  assign pinOut = padOut_q;
  assign pinOe = padOe_q;
  assign pinPullUp = pullUp_q;
  assign pinPullDown = pullDown_q;
  assign pinWeak = weak_q;
  assign pinInEn = inEn_q;
  assign pinSlewSlow = slew_q;
  assign pinLvttl = lvttl_q;
  assign dataOut = dataOut_q;
  assign pinState = pinState_q;
  assign programmableLogicBlockIn = pinState_q[FABRIC_PINS-1:0];
  assign intStatus = status_q;

  // Checks
  logic afterReset_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      afterReset_q <= 1'b0;
    end else begin
      afterReset_q <= 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_rise0;
    intEnable[0] && intEdgeSel[EDGE_RISE_BIT] && !prevState_q[0] && pinState_q[0];
  endsequence

  sequence s_status0_kept;
    status_q[0] [*2];
  endsequence

  a_reset_pins_off: assert property (
    !afterReset_q |-> (pinOe == '0 && pinPullUp == '0 && pinInEn == '0))
    else $error("pin active right after reset");

  a_hold_keeps_pad: assert property (
    holdEn [*2] |-> $stable(pinOe) && $stable(pinOut) && $stable(pinPullUp))
    else $error("pad changed during hold");

  a_out_disable_off: assert property (
    !holdEn |=> (pinOe & $past(outDisable)) == '0)
    else $error("disabled output still driving");

  a_in_disable_zero: assert property (
    !holdEn |=> (pinState & $past(inDisable)) == '0)
    else $error("disabled input sampled");

  a_high_port_no_fabric: assert property (
    !holdEn && sourceSel[FABRIC_PINS*SRC_W +: SRC_W] == SRC_FABRIC
      && driveMode[FABRIC_PINS*MODE_W +: MODE_W] == GPR_DM_STRONG
    |=> pinOut[FABRIC_PINS] == $past(dataOut_q[FABRIC_PINS]))
    else $error("high port reached fabric");

  a_fixed_route_pin: assert property (
    !holdEn && sourceSel[SRC_W-1:0] == SRC_FIXED
    |=> pinOut[0] == $past(fixedOut[0]))
    else $error("fixed source not routed");

  a_dout_write_port: assert property (
    doutWrite && doutPort == 3'h2 |=> dataOut[23:16] == $past(doutData))
    else $error("data output byte not written");

  a_pin_sample_in: assert property (
    !holdEn && cellInEn[0] |=> pinState[0] == $past(pinIn[0]))
    else $error("pin state not sampled");

  a_status_set_wins: assert property (
    s_rise0 |=> intStatus[0])
    else $error("edge event lost");

  a_status_sticky_bit: assert property (
    intStatus[0] && !intClear[0] |=> s_status0_kept or (##0 intStatus[0]))
    else $error("status bit dropped without clear");

  a_port_request_tie: assert property (
    portServiceVector[0] == |(intStatus[7:0] & intEnable[7:0]))
    else $error("port request mismatch");

  a_slew_follows_cfg: assert property (
    !holdEn |=> pinSlewSlow == $past(slewSlow))
    else $error("slew setting not applied");

  a_lvttl_follows_cfg: assert property (
    !holdEn |=> pinLvttl == $past(thresholdLvttl))
    else $error("threshold setting not applied");

  a_open_drain_low: assert property (
    !holdEn && driveMode[MODE_W-1:0] == GPR_DM_OPEN_DRAIN && !outDisable[0]
    |=> pinOe[0] != pinOut[0])
    else $error("open drain drove high");

  a_open_source_high: assert property (
    !holdEn && driveMode[MODE_W-1:0] == GPR_DM_OPEN_SOURCE && !outDisable[0]
    |=> pinOe[0] == pinOut[0])
    else $error("open source drove low");

  a_fabric_out_route: assert property (
    !holdEn && sourceSel[SRC_W-1:0] == SRC_FABRIC
    |=> pinOut[0] == $past(programmableLogicBlockOut[0]))
    else $error("fabric source not routed");

  a_fabric_in_route: assert property (
    !holdEn && cellInEn[0] |=> programmableLogicBlockIn[0] == $past(pinIn[0]))
    else $error("pin state not sent to fabric");

  a_clear_drops_status: assert property (
    intClear[0] && !pinEvent[0] |=> !intStatus[0])
    else $error("status bit survived clear");

  a_request_stays_up: assert property (
    portServiceVector[0] && intClear[7:0] == 8'h00
    |=> portServiceVector[0] || intEnable[7:0] != $past(intEnable[7:0]))
    else $error("port request dropped without clear");

  a_no_false_edge: assert property (
    !afterReset_q |-> ##2 intStatus == '0)
    else $error("interrupt raised by reset release");
endmodule

// file: src/gpr_pkg.sv
package gpr_pkg;
  localparam int NUM_PORTS = 8;
  localparam int PORT_PINS = 8;
  localparam int NUM_PINS = NUM_PORTS * PORT_PINS;
  localparam int FABRIC_PORTS = 4;
  localparam int FABRIC_PINS = FABRIC_PORTS * PORT_PINS;
  localparam int MODE_W = 3;
  localparam int SRC_W = 2;
  localparam int EDGE_W = 2;

  typedef enum logic [2:0] {
    GPR_DM_OFF = 3'h0,
    GPR_DM_INPUT = 3'h1,
    GPR_DM_RES_UP = 3'h2,
    GPR_DM_RES_DOWN = 3'h3,
    GPR_DM_OPEN_DRAIN = 3'h4,
    GPR_DM_OPEN_SOURCE = 3'h5,
    GPR_DM_STRONG = 3'h6,
    GPR_DM_WEAK = 3'h7
  } gpr_drive_t;

  // Matrix source codes
  localparam logic [1:0] SRC_DATA = 2'h0;
  localparam logic [1:0] SRC_FIXED = 2'h1;
  localparam logic [1:0] SRC_FABRIC = 2'h2;

  // Edge select bits
  localparam int EDGE_RISE_BIT = 0;
  localparam int EDGE_FALL_BIT = 1;

  localparam logic [NUM_PINS-1:0] PINS_RESET = 64'h0000_0000_0000_0000;
endpackage

// file: src/gpr_pin_cell.sv
`timescale 1ns/100ps
module gpr_pin_cell (
  // Configuration
  input wire gpr_pkg::gpr_drive_t driveMode,
  input wire logic outDisable,
  input wire logic inDisable,
  // Value from matrix
  input wire logic outValue,
  // Pad controls
  output logic padOut,
  output logic padOe,
  output logic padPullUp,
  output logic padPullDown,
  output logic padWeak,
  output logic padInEn
);
  import gpr_pkg::*;

  logic oeRaw;

  always_comb begin
    oeRaw = 1'b0;
    padOut = outValue;
    padPullUp = 1'b0;
    padPullDown = 1'b0;
    padWeak = 1'b0;
    unique case (driveMode)
      GPR_DM_OFF, GPR_DM_INPUT: begin
        oeRaw = 1'b0;
      end
      GPR_DM_RES_UP: begin
        oeRaw = !outValue;
        padPullUp = 1'b1;
      end
      GPR_DM_RES_DOWN: begin
        oeRaw = outValue;
        padPullDown = 1'b1;
      end
      GPR_DM_OPEN_DRAIN: begin
        oeRaw = !outValue;
      end
      GPR_DM_OPEN_SOURCE: begin
        oeRaw = outValue;
      end
      GPR_DM_STRONG: begin
        oeRaw = 1'b1;
      end
      GPR_DM_WEAK: begin
        padWeak = 1'b1;
        padPullUp = outValue;
        padPullDown = !outValue;
      end
    endcase
    padOe = oeRaw && !outDisable;
    padInEn = (driveMode != GPR_DM_OFF) && !inDisable;
  end
endmodule

// file: dv/gpr_pad_model.sv
`timescale 1ns/100ps
module gpr_pad_model (
  // Pad controls from the port
  input wire logic [gpr_pkg::NUM_PINS-1:0] padOut,
  input wire logic [gpr_pkg::NUM_PINS-1:0] padOe,
  input wire logic [gpr_pkg::NUM_PINS-1:0] padPullUp,
  input wire logic [gpr_pkg::NUM_PINS-1:0] padPullDown,
  // Outside drivers
  input wire logic [gpr_pkg::NUM_PINS-1:0] extVal,
  input wire logic [gpr_pkg::NUM_PINS-1:0] extEn,
  // Resolved pad level
  output logic [gpr_pkg::NUM_PINS-1:0] padLevel
);
  import gpr_pkg::*;
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      if (extEn[i]) begin
        padLevel[i] = extVal[i];
      end else if (padOe[i]) begin
        padLevel[i] = padOut[i];
      end else if (padPullUp[i] || padPullDown[i]) begin
        padLevel[i] = padPullUp[i];
      end else begin
        // Floating pad: never echo the last driven value
        padLevel[i] = ~padOut[i];
      end
    end
  end
endmodule

// file: dv/gpr_port_with_routing_tb.sv
`timescale 1ns/100ps
module gpr_port_with_routing_tb;
  import gpr_pkg::*;
  typedef struct {int sel; logic [63:0] v; int due;} gpr_note_t;
  logic clk, reset_n, holdEn, doutWrite;
  logic [191:0] driveMode;
  logic [127:0] sourceSel, intEdgeSel;
  logic [2:0] doutPort;
  logic [7:0] doutData, psv;
  logic [31:0] plbOut, plbIn, b;
  logic [63:0] inDisable, outDisable, thresholdLvttl, slewSlow, fixedOut, intEnable, intClear;
  logic [63:0] pinIn, extVal, extEn, pinOut, pinOe, pinPullUp, pinPullDown, pinWeak, pinInEn;
  logic [63:0] pinSlewSlow, pinLvttl, dataOut, pinState, intStatus, dexp, f, en, pv;
  int errors, nTests;
  int cyc = 0;
  gpr_note_t q[$];

  gpr_port_top gpr_port_top_i (.clk(clk), .reset_n(reset_n), .driveMode(driveMode),
    .inDisable(inDisable), .outDisable(outDisable), .thresholdLvttl(thresholdLvttl),
    .slewSlow(slewSlow), .sourceSel(sourceSel), .holdEn(holdEn), .doutWrite(doutWrite),
    .doutPort(doutPort), .doutData(doutData), .fixedOut(fixedOut),
    .programmableLogicBlockOut(plbOut), .intEnable(intEnable), .intEdgeSel(intEdgeSel),
    .intClear(intClear), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
    .pinPullUp(pinPullUp), .pinPullDown(pinPullDown), .pinWeak(pinWeak), .pinInEn(pinInEn),
    .pinSlewSlow(pinSlewSlow), .pinLvttl(pinLvttl), .dataOut(dataOut), .pinState(pinState),
    .programmableLogicBlockIn(plbIn), .intStatus(intStatus), .portServiceVector(psv));

  gpr_pad_model gpr_pad_model_i (.padOut(pinOut), .padOe(pinOe), .padPullUp(pinPullUp),
    .padPullDown(pinPullDown), .extVal(extVal), .extEn(extEn), .padLevel(pinIn));

  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) cyc <= cyc + 1;

  task automatic note(int s, logic [63:0] v, int d);
    q.push_back('{s, v, cyc + d});
  endtask

  function automatic logic [63:0] pick(int s);
    case (s)
      0: return pinOut;
      1: return pinOe;
      2: return dataOut;
      3: return pinState;
      4: return intStatus;
      5: return {56'h0, psv};
      6: return pinInEn;
      7: return {32'h0, plbIn};
      8: return pinSlewSlow;
      9: return pinLvttl;
      11: return pinPullDown;
      12: return pinWeak;
      default: return pinPullUp;
    endcase
  endfunction

  task automatic cmp64(logic [63:0] got, logic [63:0] exp);
    nTests++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic print_verdict;
    $display("Comparisons %0d, errors %0d", nTests, errors);
    if (errors == 0 && nTests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic step(int n);
    repeat (n) @(negedge clk);
  endtask

  // Settled outputs, oldest note first
  always @(posedge clk) begin
    #2;
    while (q.size() > 0 && q[0].due <= cyc) begin
      cmp64(pick(q[0].sel), q[0].v);
      void'(q.pop_front());
    end
  end

  initial begin
    repeat (3000) @(posedge clk);
    errors++;
    print_verdict();
  end

  initial begin
    {holdEn, doutWrite, doutPort, doutData, driveMode, sourceSel, intEdgeSel} = '0;
    {inDisable, outDisable, thresholdLvttl, slewSlow, fixedOut, plbOut} = '0;
    {intEnable, intClear, extVal, extEn, dexp, pv} = '0;
    {reset_n, errors, nTests} = '0;
    void'($urandom(65344));
    step(19);
    for (int s = 0; s < 3; s++) note(s, '0, 0);
    step(1);
    reset_n = 1;
    for (int m = 0; m < 8; m++) begin
      driveMode = {64{3'(m)}};
      note(6, {64{m != 0}}, 1);
      note(1, {64{m == 2 || m == 4 || m == 6}}, 1);
      note(10, {64{m == 2}}, 1);
      note(11, {64{m == 3 || m == 7}}, 1);
      note(12, {64{m == 7}}, 1);
      step(1);
    end
    driveMode = {64{GPR_DM_RES_UP}};
    note(10, '1, 1);
    step(1);
    driveMode = {64{GPR_DM_STRONG}};
    note(1, '1, 1);
    step(1);
    for (int p = 0; p < 8; p++) begin
      doutWrite = 1;
      doutPort = 3'(p);
      doutData = 8'($urandom);
      dexp[8*p +: 8] = doutData;
      note(2, dexp, 1);
      note(0, dexp, 2);
      step(1);
    end
    doutWrite = 0;
    step(2);
    note(3, dexp, 1);
    note(7, {32'h0, dexp[31:0]}, 1);
    step(1);
    f = {$urandom, $urandom};
    b = $urandom;
    fixedOut = f;
    plbOut = b;
    sourceSel = {64{SRC_FIXED}};
    note(0, f, 1);
    step(1);
    sourceSel = {64{SRC_FABRIC}};
    note(0, {dexp[63:32], b}, 1);
    step(1);
    sourceSel = '0;
    outDisable = '1;
    note(1, '0, 1);
    note(6, '1, 1);
    step(1);
    outDisable = '0;
    inDisable = '1;
    note(1, '1, 1);
    note(6, '0, 1);
    note(3, '0, 2);
    step(2);
    inDisable = '0;
    thresholdLvttl = f;
    slewSlow = ~f;
    note(9, f, 1);
    note(8, ~f, 1);
    step(2);
    holdEn = 1;
    step(1);
    sourceSel = {64{SRC_FIXED}};
    outDisable = '1;
    note(0, dexp, 2);
    note(1, '1, 2);
    step(3);
    holdEn = 0;
    note(0, f, 1);
    note(1, '0, 1);
    step(1);
    outDisable = '0;
    driveMode = {64{GPR_DM_INPUT}};
    extEn = '1;
    intEdgeSel = {64{2'b01}};
    en = {$urandom, $urandom};
    intEnable = en;
    for (int p = 0; p < 8; p++) pv[p] = |en[8*p +: 8];
    step(3);
    extVal = '1;
    note(4, en, 2);
    note(5, pv, 2);
    step(4);
    extVal = '0;
    note(4, en, 3);
    step(4);
    intClear = '1;
    note(4, '0, 1);
    note(5, '0, 1);
    step(1);
    intClear = '0;
    intEdgeSel = {64{2'b10}};
    extVal = '1;
    step(3);
    extVal = '0;
    note(4, en, 2);
    step(1);
    intClear = '1;
    step(1);
    intClear = '0;
    step(3);
    intEdgeSel = {64{2'b01}};
    extVal = '1;
    reset_n = 0;
    note(1, '0, 1);
    note(6, '0, 1);
    note(4, '0, 1);
    step(2);
    reset_n = 1;
    note(6, '1, 1);
    note(4, '0, 3);
    step(4);
    print_verdict();
  end
endmodule
